/* File: clf_blocks.sv */
// Math, conditional, set/reset latch and lookup table function blocks.
// Assumes all inputs come from logic on clk_sys; results register once.
`timescale 1ns/1ns

// Contract
// - Five math units, six inputs each, each input with min and max limits.
// - Inputs normalise to percent of limit span; decimal digits scale the limits.
// - Four stages cascade; each result feeds the next first operand.
// - Stage with unused second operand passes the first operand unchanged.
// - Operator codes: comparisons and logic 0 to 8, arithmetic 9 to 14.
// - For OR, AND, XOR an operand of at least one counts as true.
// - Comparison and logic results are exactly zero or one.
// - Arithmetic results saturate to the zero to full-scale percent range.
// - Divide by zero yields full scale.
// - Final percent rescales to output range; range is exported as limits.
// - Conditional unit evaluates two comparisons with operator codes 0 to 7.
// - An unselected conditional input contributes zero.
// - The two conditions combine by OR, AND or XOR.
// - Conditional output is a single boolean.
// - Latch starts off; reset wins, set turns on, otherwise hold.
// - Set and reset levels use min and max thresholds with a dead band.
// - Each lookup table holds points zero through ten.
// - Axis type 0 uses input as abscissa; 1 uses elapsed ms, input enables.
// - Segment codes ignore, ramp, jump; ramp interpolates, jump outputs point Y.
// - Point zero is always a jump; ignore disables that and later points.
// - X values must not fall and must stay within the allowed bounds.
// - Exported output min and max are extreme Y over active points.
module clf_blocks #(
	parameter int MS_CYCLES = clf_pkg::MS_CYCLES
) (
	// Clock and reset
	input logic clk_sys,
	input logic resetn,
	// Math units
	input clf_pkg::clf_math_cfg_t mathCfg [clf_pkg::NMATH],
	input clf_pkg::clf_val_t mathIn [clf_pkg::NMATH][clf_pkg::NIN],
	output clf_pkg::clf_val_t [clf_pkg::NMATH-1:0] mathOut,
	output clf_pkg::clf_val_t [clf_pkg::NMATH-1:0] mathOutMin,
	output clf_pkg::clf_val_t [clf_pkg::NMATH-1:0] mathOutMax,
	// Conditional units
	input clf_pkg::clf_cond_cfg_t condCfg [clf_pkg::NCOND],
	input clf_pkg::clf_arg_t condArg [clf_pkg::NCOND][clf_pkg::NARG],
	output logic [clf_pkg::NCOND-1:0] condOut,
	// Set/reset latches, levels in percent
	input clf_pkg::clf_latch_cfg_t latchCfg [clf_pkg::NLATCH],
	input clf_pkg::clf_val_t latchSetPct [clf_pkg::NLATCH],
	input clf_pkg::clf_val_t latchRstPct [clf_pkg::NLATCH],
	output logic [clf_pkg::NLATCH-1:0] latchOut,
	// Lookup tables
	input clf_pkg::clf_lut_cfg_t lutCfg [clf_pkg::NLUT],
	input clf_pkg::clf_val_t lutIn [clf_pkg::NLUT],
	output clf_pkg::clf_val_t [clf_pkg::NLUT-1:0] lutOut,
	output clf_pkg::clf_val_t [clf_pkg::NLUT-1:0] lutOutMin,
	output clf_pkg::clf_val_t [clf_pkg::NLUT-1:0] lutOutMax,
	output logic [clf_pkg::NLUT-1:0] lutCfgErr
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Clamp a wide value into the percent range
	function automatic clf_pkg::clf_val_t clf_sat(logic signed [63:0] t);
		if (t < 64'(clf_pkg::VAL_ZERO)) begin
			return clf_pkg::VAL_ZERO;
		end
		if (t > 64'(clf_pkg::PCT_FULL)) begin
			return clf_pkg::PCT_FULL;
		end
		return t[31:0];
	endfunction

	function automatic clf_pkg::clf_val_t clf_norm(clf_pkg::clf_val_t v,
			clf_pkg::clf_in_cfg_t c);
		logic signed [63:0] lo;
		logic signed [63:0] hi;
		lo = 64'(c.minv) * 64'(clf_pkg::DEC_SCALE[c.digits]);
		hi = 64'(c.maxv) * 64'(clf_pkg::DEC_SCALE[c.digits]);
		if (hi <= lo) begin
			return (64'(v) >= hi) ? clf_pkg::PCT_FULL : clf_pkg::VAL_ZERO;
		end
		return clf_sat((64'(v) - lo) * 64'(clf_pkg::PCT_FULL) / (hi - lo));
	endfunction

	// Select one of the normalised inputs, zero when unused or out of range
	function automatic clf_pkg::clf_val_t clf_pick(clf_pkg::clf_val_t p [clf_pkg::NIN],
			logic [2:0] sel);
		if (sel == clf_pkg::SRC_NONE || int'(sel) > clf_pkg::NIN) begin
			return clf_pkg::VAL_ZERO;
		end
		return p[int'(sel) - 1];
	endfunction

	function automatic clf_pkg::clf_val_t clf_op(clf_pkg::clf_op_t op,
			clf_pkg::clf_val_t a, clf_pkg::clf_val_t b);
		logic la;
		logic lb;
		logic signed [63:0] t;
		la = (a >= clf_pkg::PCT_TRUE);
		lb = (b >= clf_pkg::PCT_TRUE);
		t = 64'(a);
		unique case (op)
			clf_pkg::OP_EQ: t = 64'(a == b);
			clf_pkg::OP_NE: t = 64'(a != b);
			clf_pkg::OP_GT: t = 64'(a > b);
			clf_pkg::OP_GE: t = 64'(a >= b);
			clf_pkg::OP_LT: t = 64'(a < b);
			clf_pkg::OP_LE: t = 64'(a <= b);
			clf_pkg::OP_OR: t = 64'(la | lb);
			clf_pkg::OP_AND: t = 64'(la & lb);
			clf_pkg::OP_XOR: t = 64'(la ^ lb);
			clf_pkg::OP_ADD: t = 64'(a) + 64'(b);
			clf_pkg::OP_SUB: t = 64'(a) - 64'(b);
			clf_pkg::OP_MUL: t = 64'(a) * 64'(b) / 64'(clf_pkg::PCT_FULL);
			clf_pkg::OP_DIV: t = (b == clf_pkg::VAL_ZERO) ? 64'(clf_pkg::PCT_FULL) :
				64'(a) * 64'(clf_pkg::PCT_FULL) / 64'(b);
			clf_pkg::OP_MIN: t = (a < b) ? 64'(a) : 64'(b);
			clf_pkg::OP_MAX: t = (a > b) ? 64'(a) : 64'(b);
			default: t = 64'(a); // Illegal code 15 passes the operand
		endcase
		return clf_sat(t);
	endfunction

	function automatic logic clf_cmp(clf_pkg::clf_cop_t op, clf_pkg::clf_val_t a,
			clf_pkg::clf_val_t b);
		logic r;
		r = 1'b0;
		unique case (op)
			clf_pkg::CO_EQ: r = (a == b);
			clf_pkg::CO_NE: r = (a != b);
			clf_pkg::CO_GT: r = (a > b);
			clf_pkg::CO_GE: r = (a >= b);
			clf_pkg::CO_LT: r = (a < b);
			clf_pkg::CO_LE: r = (a <= b);
			clf_pkg::CO_OR: r = (a >= clf_pkg::PCT_TRUE) | (b >= clf_pkg::PCT_TRUE);
			clf_pkg::CO_AND: r = (a >= clf_pkg::PCT_TRUE) & (b >= clf_pkg::PCT_TRUE);
		endcase
		return r;
	endfunction

	// index of the last active point, stops at the first ignore
	function automatic int clf_last(clf_pkg::clf_lut_cfg_t c);
		int last;
		logic stop;
		last = 0;
		stop = 1'b0;
		for (int i = 1; i < clf_pkg::NPT; i++) begin
			if (!stop && c.rsp[i] != clf_pkg::RSP_IGNORE) begin
				last = i;
			end else begin
				stop = 1'b1;
			end
		end
		return last;
	endfunction

	// evaluate the table at abscissa v
	function automatic clf_pkg::clf_val_t clf_lut(clf_pkg::clf_val_t v,
			clf_pkg::clf_lut_cfg_t c);
		int last;
		logic hit;
		logic signed [63:0] r;
		logic signed [63:0] dx;
		last = clf_last(c);
		hit = 1'b0;
		r = 64'(c.y[0]);
		if (v > c.x[last]) begin
			r = 64'(c.y[last]);
		end else if (v > c.x[0]) begin
			for (int i = 1; i < clf_pkg::NPT; i++) begin
				if (!hit && i <= last && v <= c.x[i]) begin
					hit = 1'b1;
					dx = 64'(c.x[i]) - 64'(c.x[i-1]);
					if (c.rsp[i] == clf_pkg::RSP_RAMP && dx != 64'sh0) begin
						r = 64'(c.y[i-1]) + (64'(v) - 64'(c.x[i-1])) *
							(64'(c.y[i]) - 64'(c.y[i-1])) / dx;
					end else begin
						r = 64'(c.y[i]);
					end
				end
			end
		end
		return r[31:0];
	endfunction

	// ------------------------------------------------------------
	// State and combinational evaluation
	// ------------------------------------------------------------
	clf_pkg::clf_state_t state_reg;
	clf_pkg::clf_state_t state_next;
	clf_pkg::clf_val_t pctVal [clf_pkg::NMATH][clf_pkg::NIN];
	clf_pkg::clf_val_t stgA [clf_pkg::NMATH][clf_pkg::NSTG];
	clf_pkg::clf_val_t stgB [clf_pkg::NMATH][clf_pkg::NSTG];
	clf_pkg::clf_val_t stgRes [clf_pkg::NMATH][clf_pkg::NSTG];

	// Next state of every unit
	always_comb begin
		logic signed [63:0] span;
		clf_pkg::clf_val_t acc;
		clf_pkg::clf_val_t argv [clf_pkg::NARG];
		clf_pkg::clf_val_t absc;
		logic c1;
		logic c2;
		int last;
		span = 64'sh0;
		acc = clf_pkg::VAL_ZERO;
		absc = clf_pkg::VAL_ZERO;
		c1 = 1'b0;
		c2 = 1'b0;
		last = 0;
		argv = '{default: clf_pkg::VAL_ZERO};
		state_next = state_reg;
		// five math units of six inputs
		for (int u = 0; u < clf_pkg::NMATH; u++) begin
			for (int k = 0; k < clf_pkg::NIN; k++) begin
				pctVal[u][k] = clf_norm(mathIn[u][k], mathCfg[u].inCfg[k]);
			end
			acc = clf_pick(pctVal[u], mathCfg[u].srcA);
			for (int s = 0; s < clf_pkg::NSTG; s++) begin
				stgA[u][s] = acc;
				stgB[u][s] = clf_pick(pctVal[u], mathCfg[u].srcB[s]);
				if (mathCfg[u].srcB[s] == clf_pkg::SRC_NONE) begin
					stgRes[u][s] = acc;
				end else begin
					stgRes[u][s] = clf_op(mathCfg[u].op[s], acc, stgB[u][s]);
				end
				acc = stgRes[u][s];
			end
			span = 64'(mathCfg[u].outMax) - 64'(mathCfg[u].outMin);
			span = 64'(mathCfg[u].outMin) + 64'(acc) * span / 64'(clf_pkg::PCT_FULL);
			state_next.mathOut[u] = span[31:0];
			state_next.mathMin[u] = mathCfg[u].outMin;
			state_next.mathMax[u] = mathCfg[u].outMax;
		end
		// Conditional units
		for (int n = 0; n < clf_pkg::NCOND; n++) begin
			for (int a = 0; a < clf_pkg::NARG; a++) begin
				argv[a] = condArg[n][a].used ? condArg[n][a].val : clf_pkg::VAL_ZERO;
			end
			c1 = clf_cmp(condCfg[n].op1, argv[0], argv[1]);
			c2 = clf_cmp(condCfg[n].op2, argv[2], argv[3]);
			unique case (condCfg[n].op3)
				clf_pkg::CMB_OR: state_next.cond[n] = c1 | c2;
				clf_pkg::CMB_AND: state_next.cond[n] = c1 & c2;
				clf_pkg::CMB_XOR: state_next.cond[n] = c1 ^ c2;
				default: state_next.cond[n] = c1 | c2; // Code 3 acts as OR
			endcase
		end
		// Set/reset latches
		for (int q = 0; q < clf_pkg::NLATCH; q++) begin
			if (latchSetPct[q] >= latchCfg[q].setMax) begin
				state_next.setOn[q] = 1'b1;
			end else if (latchSetPct[q] <= latchCfg[q].setMin) begin
				state_next.setOn[q] = 1'b0;
			end
			if (latchRstPct[q] >= latchCfg[q].rstMax) begin
				state_next.rstOn[q] = 1'b1;
			end else if (latchRstPct[q] <= latchCfg[q].rstMin) begin
				state_next.rstOn[q] = 1'b0;
			end
			if (state_next.rstOn[q]) begin
				state_next.latch[q] = 1'b0;
			end else if (state_next.setOn[q]) begin
				state_next.latch[q] = 1'b1;
			end
		end
		for (int l = 0; l < clf_pkg::NLUT; l++) begin
			// time axis counts ms while enabled
			if (lutCfg[l].axis == clf_pkg::AX_TIME && lutIn[l] >= clf_pkg::PCT_TRUE) begin
				if (state_reg.lutTick[l] >= 32'(MS_CYCLES - 1)) begin
					state_next.lutTick[l] = clf_pkg::VAL_ZERO;
					if (state_reg.lutMs[l] != clf_pkg::VAL_MAX) begin
						state_next.lutMs[l] = state_reg.lutMs[l] + clf_pkg::PCT_TRUE;
					end
				end else begin
					state_next.lutTick[l] = state_reg.lutTick[l] + clf_pkg::PCT_TRUE;
				end
			end else begin
				state_next.lutTick[l] = clf_pkg::VAL_ZERO;
				state_next.lutMs[l] = clf_pkg::VAL_ZERO;
			end
			absc = (lutCfg[l].axis == clf_pkg::AX_TIME) ? state_reg.lutMs[l] : lutIn[l];
			state_next.lutOut[l] = clf_lut(absc, lutCfg[l]);
			last = clf_last(lutCfg[l]);
			state_next.lutMin[l] = lutCfg[l].y[0];
			state_next.lutMax[l] = lutCfg[l].y[0];
			state_next.lutErr[l] = (lutCfg[l].x[0] < clf_pkg::LUT_XMIN) ||
				(lutCfg[l].x[0] > clf_pkg::LUT_XMAX);
			for (int i = 1; i < clf_pkg::NPT; i++) begin
				if (i <= last) begin
					if (lutCfg[l].y[i] < state_next.lutMin[l]) begin
						state_next.lutMin[l] = lutCfg[l].y[i];
					end
					if (lutCfg[l].y[i] > state_next.lutMax[l]) begin
						state_next.lutMax[l] = lutCfg[l].y[i];
					end
					if (lutCfg[l].x[i] < lutCfg[l].x[i-1] ||
							lutCfg[l].x[i] > clf_pkg::LUT_XMAX) begin
						state_next.lutErr[l] = 1'b1;
					end
				end
			end
		end
	end

	// State register; latches start off
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// boolean conditional result
	assign condOut = state_reg.cond;
	assign mathOut = state_reg.mathOut;
	assign mathOutMin = state_reg.mathMin;
	assign mathOutMax = state_reg.mathMax;
	assign latchOut = state_reg.latch;
	assign lutOut = state_reg.lutOut;
	assign lutOutMin = state_reg.lutMin;
	assign lutOutMax = state_reg.lutMax;
	assign lutCfgErr = state_reg.lutErr;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_stage_chain: assert property (@(posedge clk_sys) disable iff (!resetn)
		stgA[0][1] == stgRes[0][0]) else $error("stage cascade broken");
	a_stage_pass: assert property (@(posedge clk_sys) disable iff (!resetn)
		mathCfg[0].srcB[1] == clf_pkg::SRC_NONE |-> stgRes[0][1] == stgA[0][1])
		else $error("unused operand did not pass through");
	a_logic_binary: assert property (@(posedge clk_sys) disable iff (!resetn)
		mathCfg[0].srcB[0] != clf_pkg::SRC_NONE && mathCfg[0].op[0] <= clf_pkg::OP_XOR
		|-> stgRes[0][0] == clf_pkg::VAL_ZERO || stgRes[0][0] == clf_pkg::PCT_TRUE)
		else $error("logic result not zero or one");
	a_arith_sat: assert property (@(posedge clk_sys) disable iff (!resetn)
		mathCfg[0].srcB[0] != clf_pkg::SRC_NONE && mathCfg[0].op[0] >= clf_pkg::OP_ADD
		|-> stgRes[0][0] >= clf_pkg::VAL_ZERO && stgRes[0][0] <= clf_pkg::PCT_FULL)
		else $error("arithmetic result out of range");
	a_div_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		mathCfg[0].op[0] == clf_pkg::OP_DIV && mathCfg[0].srcB[0] != clf_pkg::SRC_NONE
		&& stgB[0][0] == clf_pkg::VAL_ZERO |-> stgRes[0][0] == clf_pkg::PCT_FULL)
		else $error("zero divisor not full scale");
	a_out_limits: assert property (@(posedge clk_sys) disable iff (!resetn)
		##1 mathOutMax[0] == $past(mathCfg[0].outMax))
		else $error("exported limit not the output range");
	a_latch_rst: assert property (@(posedge clk_sys) disable iff (!resetn)
		latchRstPct[0] >= latchCfg[0].rstMax |=> !latchOut[0])
		else $error("reset did not clear latch");
	a_latch_set: assert property (@(posedge clk_sys) disable iff (!resetn)
		latchCfg[0].rstMin < latchCfg[0].rstMax && latchRstPct[0] <= latchCfg[0].rstMin
		&& latchSetPct[0] >= latchCfg[0].setMax |=> latchOut[0])
		else $error("set did not turn latch on");
	a_lut_low: assert property (@(posedge clk_sys) disable iff (!resetn)
		lutCfg[0].axis == clf_pkg::AX_DATA && lutIn[0] < lutCfg[0].x[0]
		|=> lutOut[0] == $past(lutCfg[0].y[0]))
		else $error("low input not clamped to first point");
	a_lut_order: assert property (@(posedge clk_sys) disable iff (!resetn)
		##1 lutOutMin[0] <= lutOutMax[0] && lutOutMin[0] <= $past(lutCfg[0].y[0]))
		else $error("table min above max");

endmodule

/* File: clf_pkg.sv */
// Shared constants, encodings and carriers for the logic function blocks.
// Assumes one 100 MHz clock; every value is a signed 32-bit word.
package clf_pkg;
	// ------------------------------------------------------------
	// Unit counts
	// ------------------------------------------------------------
	localparam int NMATH = 5;
	localparam int NIN = 6;
	localparam int NSTG = 4;
	localparam int NCOND = 4;
	localparam int NARG = 4;
	localparam int NLATCH = 2;
	localparam int NLUT = 4;
	localparam int NPT = 11;

	// ------------------------------------------------------------
	// Scaling and limits
	// ------------------------------------------------------------
	typedef logic signed [31:0] clf_val_t;
	localparam clf_val_t VAL_ZERO = 32'sh0000_0000;
	localparam clf_val_t PCT_TRUE = 32'sh0000_0001; // Logic true level
	localparam clf_val_t PCT_FULL = 32'sh0000_2710; // 100.00 percent
	localparam clf_val_t LUT_XMIN = -32'sh0001_86a0;
	localparam clf_val_t LUT_XMAX = 32'sh000f_4240;
	localparam clf_val_t VAL_MAX = 32'sh7fff_ffff;
	localparam clf_val_t DEC_SCALE [4] = '{32'sh1, 32'sha, 32'sh64, 32'sh3e8};
	localparam logic [2:0] SRC_NONE = 3'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int TICK_MS = 1;
	localparam int CLK_KHZ = 100000;
	localparam int MS_CYCLES = TICK_MS * CLK_KHZ;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_EQ = 4'h0, OP_NE = 4'h1, OP_GT = 4'h2, OP_GE = 4'h3, OP_LT = 4'h4,
		OP_LE = 4'h5, OP_OR = 4'h6, OP_AND = 4'h7, OP_XOR = 4'h8, OP_ADD = 4'h9,
		OP_SUB = 4'ha, OP_MUL = 4'hb, OP_DIV = 4'hc, OP_MIN = 4'hd, OP_MAX = 4'he
	} clf_op_t;
	typedef enum logic [2:0] {
		CO_EQ = 3'h0, CO_NE = 3'h1, CO_GT = 3'h2, CO_GE = 3'h3,
		CO_LT = 3'h4, CO_LE = 3'h5, CO_OR = 3'h6, CO_AND = 3'h7
	} clf_cop_t;
	typedef enum logic [1:0] {CMB_OR = 2'h0, CMB_AND = 2'h1, CMB_XOR = 2'h2} clf_cmb_t;
	typedef enum logic [1:0] {RSP_IGNORE = 2'h0, RSP_RAMP = 2'h1, RSP_JUMP = 2'h2} clf_rsp_t;
	typedef enum logic {AX_DATA = 1'b0, AX_TIME = 1'b1} clf_axis_t;

	// ------------------------------------------------------------
	// Configuration carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] digits;
		clf_val_t minv;
		clf_val_t maxv;
	} clf_in_cfg_t;
	typedef struct packed {
		clf_in_cfg_t [NIN-1:0] inCfg;
		logic [2:0] srcA;
		logic [NSTG-1:0][2:0] srcB;
		clf_op_t [NSTG-1:0] op;
		clf_val_t outMin;
		clf_val_t outMax;
	} clf_math_cfg_t;
	typedef struct packed {
		logic used;
		clf_val_t val;
	} clf_arg_t;
	typedef struct packed {
		clf_cop_t op1;
		clf_cop_t op2;
		clf_cmb_t op3;
	} clf_cond_cfg_t;
	typedef struct packed {
		clf_val_t setMin;
		clf_val_t setMax;
		clf_val_t rstMin;
		clf_val_t rstMax;
	} clf_latch_cfg_t;
	typedef struct packed {
		clf_axis_t axis;
		clf_rsp_t [NPT-1:0] rsp;
		clf_val_t [NPT-1:0] x;
		clf_val_t [NPT-1:0] y;
	} clf_lut_cfg_t;

	// ------------------------------------------------------------
	// Block state
	// ------------------------------------------------------------
	typedef struct packed {
		clf_val_t [NMATH-1:0] mathOut;
		clf_val_t [NMATH-1:0] mathMin;
		clf_val_t [NMATH-1:0] mathMax;
		logic [NCOND-1:0] cond;
		logic [NLATCH-1:0] setOn;
		logic [NLATCH-1:0] rstOn;
		logic [NLATCH-1:0] latch;
		clf_val_t [NLUT-1:0] lutOut;
		clf_val_t [NLUT-1:0] lutMin;
		clf_val_t [NLUT-1:0] lutMax;
		clf_val_t [NLUT-1:0] lutMs;
		clf_val_t [NLUT-1:0] lutTick;
		logic [NLUT-1:0] lutErr;
	} clf_state_t;
endpackage

/* File: clf_blocks_tb.sv */
// Self-checking bench for the logic function blocks, random plus corners.
// Assumes clf_pkg and clf_blocks are compiled first; one 100 MHz clock.
`timescale 1ns/1ns
module clf_blocks_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys;
	logic resetn;
	clf_pkg::clf_math_cfg_t mathCfg [5];
	clf_pkg::clf_val_t mathIn [5][6];
	clf_pkg::clf_val_t [4:0] mathOut, mathOutMin, mathOutMax;
	clf_pkg::clf_cond_cfg_t condCfg [4];
	clf_pkg::clf_arg_t condArg [4][4];
	logic [3:0] condOut;
	clf_pkg::clf_latch_cfg_t latchCfg [2];
	clf_pkg::clf_val_t latchSetPct [2], latchRstPct [2];
	logic [1:0] latchOut;
	clf_pkg::clf_lut_cfg_t lutCfg [4];
	clf_pkg::clf_val_t lutIn [4];
	clf_pkg::clf_val_t [3:0] lutOut, lutOutMin, lutOutMax;
	logic [3:0] lutCfgErr;
	int num_errors = 0;
	int n_checks = 0;
	int seed = 39;
	longint eM [5], eL [4], eLo [4], eHi [4];
	bit eC [4], eE [4], sOn [2], rOn [2], lat [2];
	localparam clf_pkg::clf_val_t LVL [5] = '{32'sh0, 32'sh7d0, 32'sh1388, 32'sh1b58, 32'sh2710};

	clf_blocks #(.MS_CYCLES(4)) clf_blocks_inst (.clk_sys(clk_sys), .resetn(resetn),
		.mathCfg(mathCfg), .mathIn(mathIn), .mathOut(mathOut), .mathOutMin(mathOutMin),
		.mathOutMax(mathOutMax), .condCfg(condCfg), .condArg(condArg), .condOut(condOut),
		.latchCfg(latchCfg), .latchSetPct(latchSetPct), .latchRstPct(latchRstPct),
		.latchOut(latchOut), .lutCfg(lutCfg), .lutIn(lutIn), .lutOut(lutOut),
		.lutOutMin(lutOutMin), .lutOutMax(lutOutMax), .lutCfgErr(lutCfgErr));

	// ----------------------------------------
	// Reference functions
	// ----------------------------------------
	// Stage or condition operator on percent operands
	function automatic longint mop(int op, longint a, longint b);
		longint r;
		case (op)
			0: r = a == b;
			1: r = a != b;
			2: r = a > b;
			3: r = a >= b;
			4: r = a < b;
			5: r = a <= b;
			6: r = (a >= 1) | (b >= 1);
			7: r = (a >= 1) & (b >= 1);
			8: r = (a >= 1) ^ (b >= 1);
			9: r = a + b;
			10: r = a - b;
			11: r = a * b / clf_pkg::PCT_FULL;
			12: r = (b == 0) ? clf_pkg::PCT_FULL : a * clf_pkg::PCT_FULL / b;
			13: r = (a < b) ? a : b;
			default: r = (a > b) ? a : b;
		endcase
		if (op >= 9)
			r = (r < 0) ? 0 : (r > clf_pkg::PCT_FULL) ? clf_pkg::PCT_FULL : r;
		return r;
	endfunction

	// Input normalised to percent of its limit span
	function automatic longint pct(clf_pkg::clf_in_cfg_t c, longint v);
		longint lo;
		longint hi;
		longint p;
		lo = c.minv * (10 ** c.digits);
		hi = c.maxv * (10 ** c.digits);
		if (hi <= lo)
			return (v >= hi) ? clf_pkg::PCT_FULL : 0;
		p = (v - lo) * clf_pkg::PCT_FULL / (hi - lo);
		return (p < 0) ? 0 : (p > clf_pkg::PCT_FULL) ? clf_pkg::PCT_FULL : p;
	endfunction

	// Cascaded math unit rescaled to output range
	function automatic longint mathf(int u);
		longint acc;
		clf_pkg::clf_math_cfg_t c;
		c = mathCfg[u];
		acc = (c.srcA inside {[1:6]}) ? pct(c.inCfg[c.srcA-1], mathIn[u][c.srcA-1]) : 0;
		for (int s = 0; s < 4; s++)
			if (c.srcB[s] inside {[1:6]})
				acc = mop(c.op[s], acc, pct(c.inCfg[c.srcB[s]-1], mathIn[u][c.srcB[s]-1]));
		return c.outMin + acc * (c.outMax - c.outMin) / clf_pkg::PCT_FULL;
	endfunction

	// Table output, active Y range and X order error
	function automatic longint lutf(clf_pkg::clf_lut_cfg_t c, longint v, output longint lo,
		output longint hi, output bit err);
		int n;
		n = 1;
		while (n < 11 && c.rsp[n] != clf_pkg::RSP_IGNORE)
			n++;
		lo = c.y[0];
		hi = c.y[0];
		err = 0;
		for (int i = 0; i < n; i++) begin
			lo = (c.y[i] < lo) ? c.y[i] : lo;
			hi = (c.y[i] > hi) ? c.y[i] : hi;
			err |= c.x[i] < clf_pkg::LUT_XMIN || c.x[i] > clf_pkg::LUT_XMAX;
			err |= i > 0 && c.x[i] < c.x[i-1];
		end
		// Upper clamp is tested first, as in the block, for falling X tables
		if (v > c.x[n-1])
			return c.y[n-1];
		if (v <= c.x[0])
			return c.y[0];
		for (int i = 1; i < n; i++)
			if (v <= c.x[i]) begin
				if (c.rsp[i] == clf_pkg::RSP_JUMP || c.x[i] == c.x[i-1])
					return c.y[i];
				return c.y[i-1] + (v - c.x[i-1]) * (c.y[i] - c.y[i-1]) / (c.x[i] - c.x[i-1]);
			end
		return c.y[n-1];
	endfunction

	// ----------------------------------------
	// Compare and verdict
	// ----------------------------------------
	task automatic chk(string n, clf_pkg::clf_val_t s, clf_pkg::clf_val_t e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %0d got %0d", n, e, s);
		end
	endtask

	task automatic end_of_test();
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Clock and watchdog
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		resetn = 0;
		mathCfg = '{default: '0};
		mathIn = '{default: '0};
		condCfg = '{default: '0};
		condArg = '{default: '0};
		latchCfg = '{default: '{32'sh0bb8, 32'sh1b58, 32'sh0bb8, 32'sh1b58}};
		latchSetPct = '{default: '0};
		latchRstPct = '{default: '0};
		lutCfg = '{default: '0};
		lutIn = '{default: '0};
		repeat (4) @(negedge clk_sys);
		chk("latch init", latchOut, 0);
		resetn = 1;
		for (int it = 0; it < 400; it++) begin
			for (int u = 0; u < 5; u++) begin
				for (int k = 0; k < 6; k++) begin
					mathCfg[u].inCfg[k] = '{2'($random(seed)), $random(seed) % 100, $random(seed) % 200};
					mathIn[u][k] = ($random(seed) % 400) * (10 ** mathCfg[u].inCfg[k].digits);
				end
				mathCfg[u].srcA = 3'($unsigned($random(seed)) % 7);
				for (int s = 0; s < 4; s++) begin
					mathCfg[u].srcB[s] = 3'($unsigned($random(seed)) % 7);
					mathCfg[u].op[s] = clf_pkg::clf_op_t'($unsigned($random(seed)) % 15);
				end
				mathCfg[u].outMin = $random(seed) % 1000;
				mathCfg[u].outMax = $random(seed) % 5000;
				eM[u] = mathf(u);
			end
			for (int c = 0; c < 4; c++) begin
				condCfg[c] = '{clf_pkg::clf_cop_t'(3'($random(seed))),
					clf_pkg::clf_cop_t'(3'($random(seed))),
					clf_pkg::clf_cmb_t'(2'($unsigned($random(seed)) % 3))};
				for (int a = 0; a < 4; a++)
					condArg[c][a] = '{1'($random(seed)), $random(seed) % 4};
				eC[c] = mop(condCfg[c].op1, condArg[c][0].used ? condArg[c][0].val : 0,
					condArg[c][1].used ? condArg[c][1].val : 0);
				eE[c] = mop(condCfg[c].op2, condArg[c][2].used ? condArg[c][2].val : 0,
					condArg[c][3].used ? condArg[c][3].val : 0);
				eC[c] = (condCfg[c].op3 == 0) ? eC[c] | eE[c] : (condCfg[c].op3 == 1) ?
					eC[c] & eE[c] : eC[c] ^ eE[c];
			end
			for (int l = 0; l < 2; l++) begin
				latchSetPct[l] = LVL[$unsigned($random(seed)) % 5];
				latchRstPct[l] = LVL[$unsigned($random(seed)) % 5];
				sOn[l] = (latchSetPct[l] >= 32'sh1b58) ? 1 : (latchSetPct[l] < 32'sh0bb8) ? 0 : sOn[l];
				rOn[l] = (latchRstPct[l] >= 32'sh1b58) ? 1 : (latchRstPct[l] < 32'sh0bb8) ? 0 : rOn[l];
				lat[l] = rOn[l] ? 0 : sOn[l] ? 1 : lat[l];
			end
			for (int t = 0; t < 4; t++) begin
				for (int p = 0; p < 11; p++) begin
					lutCfg[t].rsp[p] = clf_pkg::clf_rsp_t'(1 + $unsigned($random(seed)) % 2);
					lutCfg[t].x[p] = (p == 0) ? $random(seed) % 100 :
						lutCfg[t].x[p-1] + $unsigned($random(seed)) % 50;
					lutCfg[t].y[p] = $random(seed) % 5000;
				end
				lutCfg[t].rsp[$unsigned($random(seed)) % 11] = clf_pkg::RSP_IGNORE;
				if (it % 8 == 0)
					lutCfg[t].x[1] = lutCfg[t].x[0] - 1;
				if (it % 8 == 4)
					lutCfg[t].x[0] = clf_pkg::LUT_XMIN - 1;
				if (it % 8 == 6)
					lutCfg[t].x[10] = clf_pkg::LUT_XMAX + 1;
				lutIn[t] = (it % 8 == 2) ? lutCfg[t].x[3] : lutCfg[t].x[0] - 20 + $random(seed) % 600;
				eL[t] = lutf(lutCfg[t], lutIn[t], eLo[t], eHi[t], eE[t]);
			end
			@(negedge clk_sys);
			for (int u = 0; u < 5; u++) begin
				chk("mathOut", mathOut[u], eM[u]);
				chk("mathOutMin", mathOutMin[u], mathCfg[u].outMin);
				chk("mathOutMax", mathOutMax[u], mathCfg[u].outMax);
			end
			for (int c = 0; c < 4; c++)
				chk("condOut", condOut[c], eC[c]);
			for (int l = 0; l < 2; l++)
				chk("latchOut", latchOut[l], lat[l]);
			for (int t = 0; t < 4; t++) begin
				chk("lutOut", lutOut[t], eL[t]);
				chk("lutOutMin", lutOutMin[t], eLo[t]);
				chk("lutOutMax", lutOutMax[t], eHi[t]);
				chk("lutCfgErr", lutCfgErr[t], eE[t]);
			end
		end
		// elapsed time ramp, 4 cycles per ms
		lutCfg[0] = '0;
		lutCfg[0].axis = clf_pkg::AX_TIME;
		lutCfg[0].rsp[1] = clf_pkg::RSP_RAMP;
		lutCfg[0].x[1] = 32'sh64;
		lutCfg[0].y[1] = 32'sh3e8;
		lutIn[0] = 0;
		repeat (2) @(negedge clk_sys);
		chk("time idle", lutOut[0], 0);
		lutIn[0] = 1;
		repeat (41) @(negedge clk_sys);
		chk("time ramp", lutOut[0], 32'sh64);
		chk("time max", lutOutMax[0], 32'sh3e8);
		lutIn[0] = 0;
		repeat (2) @(negedge clk_sys);
		chk("time clear", lutOut[0], 0);
		end_of_test();
	end
endmodule
